// ---- design/qdc_pkg.sv ----
// Constants and types for the quad converter serial command port
package qdc_pkg;
  localparam int          CLK_NS     = 40;
  localparam int          FRAME_BITS = 24;
  localparam int          DATA_W     = 16;
  localparam int          NUM_CH     = 4;
  localparam int          FIFO_DEPTH = 8;
  localparam int          SETTLE_NS  = 200;
  localparam int          SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [2:0]  SETTLE_MAX = 3'(SETTLE_CYC - 1);
  localparam logic [1:0]  INIT_CYC   = 2'h3;
  localparam logic [4:0]  LAST_BIT   = 5'h17;
  localparam logic [4:0]  OVER_BIT   = 5'h18;
  localparam logic [5:0]  SYNC_RST   = 6'h09;
  localparam logic [15:0] CODE_ZERO  = 16'h0000;
  localparam logic [15:0] CODE_MID   = 16'h8000;
  localparam int          PD_W       = 8;
  localparam int          MASK_W     = 4;
  localparam int          ENABLE_BIT = 0;
  localparam logic [3:0]  CMD_WR_IN  = 4'h1;
  localparam logic [3:0]  CMD_UPD    = 4'h2;
  localparam logic [3:0]  CMD_WR_UPD = 4'h3;
  localparam logic [3:0]  CMD_PWR    = 4'h4;
  localparam logic [3:0]  CMD_MASK   = 4'h5;
  localparam logic [3:0]  CMD_SRST   = 4'h6;
  localparam logic [3:0]  CMD_REF    = 4'h7;
  localparam logic [3:0]  CMD_CHAIN  = 4'h8;
  localparam logic [3:0]  CMD_RDBK   = 4'h9;

  typedef struct packed {
    logic [3:0]  cmd;
    logic [3:0]  addr;
    logic [15:0] data;
  } qdc_frame_type;

  typedef struct packed {
    logic [7:0] power_down;
    logic [3:0] load_mask;
    logic       ref_disable;
    logic       chain_en;
    logic       readback_en;
  } qdc_setup_type;

  localparam qdc_setup_type SETUP_RST = '{8'h00, 4'h0, 1'b0, 1'b0, 1'b0};

  typedef enum logic [2:0] {
    ST_INIT = 3'b001,
    ST_IDLE = 3'b010,
    ST_BUSY = 3'b100
  } qdc_state_type;
endpackage : qdc_pkg

// ---- design/qdc_fifo.sv ----
// Frame FIFO with valid/ready on both sides
`timescale 1ns/10ps
module qdc_fifo #(
  parameter int W     = 24,
  parameter int DEPTH = 8
) (
  input  wire logic         sys_clk_in,
  input  wire logic         rst_n_in,
  input  wire logic [W-1:0] in_data_in,
  input  wire logic         in_valid_in,
  output logic              in_ready_out,
  output logic [W-1:0]      out_data_out,
  output logic              out_valid_out,
  input  wire logic         out_ready_in
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_q [DEPTH];
  logic [AW:0]  wr_q;
  logic [AW:0]  rd_q;
  logic         push;
  logic         pop;

  assign in_ready_out  = (wr_q - rd_q) != (AW+1)'(DEPTH);
  assign out_valid_out = wr_q != rd_q;
  assign out_data_out  = mem_q[rd_q[AW-1:0]];
  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_valid_out & out_ready_in;

  always_ff @(posedge sys_clk_in) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data_in;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule : qdc_fifo

// ---- design/qdc_link_rx.sv ----
// Serial link receiver on the host's serial clock
`timescale 1ns/10ps
module qdc_link_rx
  import qdc_pkg::*;
(
  input  wire logic          link_clk_in,
  input  wire logic          rst_n_in,
  input  wire logic          frame_n_in,
  input  wire logic          serial_in,
  input  wire logic          chain_enable_in,
  input  wire logic          readback_en_in,
  input  wire logic [23:0]   readback_word_in,
  output qdc_frame_type      frame_out,
  output logic               frame_tgl_out,
  output logic               abort_tgl_out,
  output logic               serial_out_out
);
  logic [23:0] shift_q;
  logic [4:0]  count_q;
  logic [1:0]  lsync1_q;
  logic [1:0]  lsync2_q;
  logic        frame_rst_n;
  logic [4:0]  rb_idx;

  // The frame's own select line clears the bit counter; the clock may stop
  assign frame_rst_n = rst_n_in & ~frame_n_in;
  assign rb_idx      = LAST_BIT - count_q;

  always_ff @(posedge link_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lsync1_q <= 2'h0;
      lsync2_q <= 2'h0;
    end else begin
      lsync1_q <= {readback_en_in, chain_enable_in};
      lsync2_q <= lsync1_q;
    end
  end

  // shift MSB first
  // Shifter survives the gap so the chain output can replay the last frame
  always_ff @(posedge link_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      shift_q <= 24'h000000;
    end else if (!frame_n_in && count_q <= LAST_BIT) begin
      shift_q <= {shift_q[22:0], serial_in};
    end
  end

  always_ff @(posedge link_clk_in or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      count_q        <= 5'h00;
      serial_out_out <= 1'b0;
    end else begin
      if (count_q <= LAST_BIT || count_q == OVER_BIT) begin
        count_q <= count_q + 5'h01;
      end
      // chain passes old bits on, one frame late
      if (lsync2_q[0]) begin
        serial_out_out <= shift_q[23];
      end else if (lsync2_q[1] && count_q <= LAST_BIT) begin
        serial_out_out <= readback_word_in[rb_idx];
      end else begin
        serial_out_out <= 1'b0;
      end
    end
  end

  // exact length: bit 24 captures, bit 25 aborts
  always_ff @(posedge link_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      frame_out     <= '0;
      frame_tgl_out <= 1'b0;
      abort_tgl_out <= 1'b0;
    end else begin
      if (!frame_n_in && count_q == LAST_BIT) begin
        frame_out     <= {shift_q[22:0], serial_in};
        frame_tgl_out <= ~frame_tgl_out;
      end
      if (!frame_n_in && count_q == OVER_BIT) begin
        abort_tgl_out <= ~abort_tgl_out;
      end
    end
  end
endmodule : qdc_link_rx

// ---- design/qdc_command_port.sv ----
// Command decoder and channel registers of the quad converter port
`timescale 1ns/10ps
module qdc_command_port
  import qdc_pkg::*;
(
  input  wire logic          sys_clk_in,
  input  wire logic          rst_n_in,
  input  wire logic          link_clk_in,
  input  wire logic          frame_n_in,
  input  wire logic          serial_in,
  output logic               serial_out_out,
  input  wire logic          load_outputs_n_in,
  input  wire logic          power_on_code_select_in,
  input  wire logic          gain_select_in,
  output logic [3:0][15:0]   dac_code_out,
  output logic               gain_double_out,
  output qdc_setup_type      setup_out,
  output logic               busy_out
);
  // ************************************************************
  // Link side and crossing
  // ************************************************************
  qdc_frame_type link_frame;
  logic          frame_tgl;
  logic          abort_tgl;
  logic [23:0]   rb_word_q;
  logic [5:0]    sync1_q;
  logic [5:0]    sync2_q;
  logic [1:0]    tgl_prev_q;
  logic          load_prev_q;
  logic          frame_ev;
  logic          abort_ev;
  logic          load_outputs_n_fall;
  logic          pend_q;
  logic          push;
  logic          fifo_in_ready;

  qdc_link_rx u_link (
    .link_clk_in      (link_clk_in),
    .rst_n_in         (rst_n_in),
    .frame_n_in       (frame_n_in),
    .serial_in        (serial_in),
    .chain_enable_in  (setup_out.chain_en),
    .readback_en_in   (setup_out.readback_en),
    .readback_word_in (rb_word_q),
    .frame_out        (link_frame),
    .frame_tgl_out    (frame_tgl),
    .abort_tgl_out    (abort_tgl),
    .serial_out_out   (serial_out_out)
  );

  // Bits: 0 select, 1 frame, 2 abort, 3 load pin, 4 code strap, 5 gain strap
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1_q <= SYNC_RST;
      sync2_q <= SYNC_RST;
    end else begin
      sync1_q <= {gain_select_in, power_on_code_select_in, load_outputs_n_in,
                  abort_tgl, frame_tgl, frame_n_in};
      sync2_q <= sync1_q;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tgl_prev_q  <= 2'h0;
      load_prev_q <= 1'b1;
    end else begin
      tgl_prev_q  <= sync2_q[2:1];
      load_prev_q <= sync2_q[3];
    end
  end

  assign frame_ev  = sync2_q[1] ^ tgl_prev_q[0];
  assign abort_ev  = sync2_q[2] ^ tgl_prev_q[1];
  assign load_outputs_n_fall = load_prev_q & ~sync2_q[3];
  // act only once select has returned high
  assign push      = pend_q & sync2_q[0] & fifo_in_ready;

  // Captured word stays put until the next frame's 24th bit
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pend_q <= 1'b0;
    end else if (abort_ev) begin
      pend_q <= 1'b0;
    end else if (frame_ev) begin
      pend_q <= 1'b1;
    end else if (push) begin
      pend_q <= 1'b0;
    end
  end

  // ************************************************************
  // Frame FIFO
  // ************************************************************
  qdc_frame_type f;
  logic          fifo_valid;
  logic          exec;
  qdc_state_type st_q;

  qdc_fifo #(
    .W     (FRAME_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_in    (sys_clk_in),
    .rst_n_in      (rst_n_in),
    .in_data_in    (link_frame),
    .in_valid_in   (push),
    .in_ready_out  (fifo_in_ready),
    .out_data_out  (f),
    .out_valid_out (fifo_valid),
    .out_ready_in  (st_q == ST_IDLE)
  );

  assign exec = (st_q == ST_IDLE) & fifo_valid;

  // ************************************************************
  // Control sequence
  // ************************************************************
  logic [1:0]    init_q;
  logic [2:0]    settle_q;
  logic          pocs_q;
  logic          gain_q;
  logic          init_load;
  logic          soft_rst;
  logic          restore;
  logic [15:0]   por_code;
  logic [3:0]    wr_in;
  logic [3:0]    cp;
  logic          any_cp;
  qdc_setup_type setup_q;
  logic [15:0]   in_q  [NUM_CH];
  logic [15:0]   dac_q [NUM_CH];

  assign init_load = (st_q == ST_INIT) && (init_q == INIT_CYC);
  assign soft_rst  = exec && f.cmd == CMD_SRST;
  assign restore   = init_load | soft_rst;
  assign por_code  = (init_load ? sync2_q[4] : pocs_q) ? CODE_MID : CODE_ZERO;
  assign any_cp    = |cp;

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q <= ST_INIT;
    end else begin
      case (st_q)
        ST_INIT: begin
          if (init_q == INIT_CYC) begin
            st_q <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (exec && any_cp) begin
            st_q <= ST_BUSY;
          end
        end
        ST_BUSY: begin
          if (settle_q == 3'h0) begin
            st_q <= ST_IDLE;
          end
        end
        default: st_q <= ST_INIT;
      endcase
    end
  end

  // Output settling time stalls the FIFO drain
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      settle_q <= 3'h0;
      init_q   <= 2'h0;
    end else begin
      if (st_q == ST_IDLE) begin
        settle_q <= SETTLE_MAX;
      end else if (settle_q != 3'h0) begin
        settle_q <= settle_q - 3'h1;
      end
      if (st_q == ST_INIT) begin
        init_q <= init_q + 2'h1;
      end
    end
  end

  // Straps are sampled once, after the synchronisers have settled
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pocs_q <= 1'b0;
      gain_q <= 1'b0;
    end else if (init_load) begin
      pocs_q <= sync2_q[4];
      gain_q <= sync2_q[5];
    end
  end

  // ************************************************************
  // Channel registers
  // ************************************************************
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      wr_in[i] = exec && f.addr[i] && (f.cmd == CMD_WR_IN || f.cmd == CMD_WR_UPD);
      cp[i] = (exec && f.addr[i] && (f.cmd == CMD_UPD || f.cmd == CMD_WR_UPD))
            || (wr_in[i] && f.cmd == CMD_WR_IN && !sync2_q[3] && !setup_q.load_mask[i])
            || (load_outputs_n_fall && !setup_q.load_mask[i] && st_q != ST_INIT);
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < NUM_CH; i++) begin
        in_q[i]  <= CODE_ZERO;
        dac_q[i] <= CODE_ZERO;
      end
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (restore) begin
          in_q[i]  <= por_code;
          dac_q[i] <= por_code;
        end else begin
          if (wr_in[i]) begin
            in_q[i] <= f.data;
          end
          if (cp[i]) begin
            dac_q[i] <= wr_in[i] ? f.data : in_q[i];
          end
        end
      end
    end
  end

  // ************************************************************
  // Setup registers
  // ************************************************************
  // unlisted codes fall through untouched
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      setup_q <= SETUP_RST;
    end else if (restore) begin
      setup_q <= SETUP_RST;
    end else if (exec) begin
      case (f.cmd)
        CMD_PWR:   setup_q.power_down  <= f.data[PD_W-1:0];
        CMD_MASK:  setup_q.load_mask   <= f.data[MASK_W-1:0];
        CMD_REF:   setup_q.ref_disable <= f.data[ENABLE_BIT];
        CMD_CHAIN: setup_q.chain_en    <= f.data[ENABLE_BIT];
        CMD_RDBK:  setup_q.readback_en <= f.data[ENABLE_BIT];
        default:   setup_q <= setup_q;
      endcase
    end
  end

  // word returned on the next frame
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rb_word_q <= 24'h000000;
    end else if (exec && f.cmd == CMD_RDBK) begin
      rb_word_q <= {f.cmd, f.addr, f.addr[0] ? in_q[0] : f.addr[1] ? in_q[1] :
                    f.addr[2] ? in_q[2] : in_q[3]};
    end
  end

  // codes and gain go to the analog stage
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      dac_code_out[i] = dac_q[i];
    end
  end
  assign gain_double_out = gain_q;
  assign setup_out       = setup_q;
  assign busy_out        = st_q != ST_IDLE;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  property p_push_at_rise;
    push |=> fifo_valid;
  endproperty
  a_push_at_rise: assert property (p_push_at_rise) else $error("committed frame not queued");

  property p_chan_a;
    exec && f.cmd == CMD_WR_UPD && f.addr[0] |=> dac_q[0] == $past(f.data) && in_q[0] == $past(f.data);
  endproperty
  a_chan_a: assert property (p_chan_a) else $error("channel A write lost");

  property p_wr_in;
    exec && f.cmd == CMD_WR_IN && f.addr[1] |=> in_q[1] == $past(f.data);
  endproperty
  a_wr_in: assert property (p_wr_in) else $error("input register not written");

  property p_wr_in_hold;
    exec && f.cmd == CMD_WR_IN && f.addr[1] && sync2_q[3] && !load_outputs_n_fall |=> $stable(dac_q[1]);
  endproperty
  a_wr_in_hold: assert property (p_wr_in_hold) else $error("output moved with load pin high");

  property p_upd;
    exec && f.cmd == CMD_UPD && f.addr[2] |=> dac_q[2] == $past(in_q[2]);
  endproperty
  a_upd: assert property (p_upd) else $error("update did not copy input");

  property p_wr_upd;
    exec && f.cmd == CMD_WR_UPD && f.addr[3] |=> dac_q[3] == $past(f.data);
  endproperty
  a_wr_upd: assert property (p_wr_upd) else $error("write and update failed");

  property p_pwr;
    exec && f.cmd == CMD_PWR |=> setup_q.power_down == $past(f.data[7:0]);
  endproperty
  a_pwr: assert property (p_pwr) else $error("power-down not loaded");

  property p_srst;
    soft_rst |=> dac_q[0] == (pocs_q ? CODE_MID : CODE_ZERO) && setup_q == SETUP_RST;
  endproperty
  a_srst: assert property (p_srst) else $error("soft reset incomplete");

  property p_mask;
    exec && f.cmd == CMD_MASK |=> setup_q.load_mask == $past(f.data[3:0]);
  endproperty
  a_mask: assert property (p_mask) else $error("mask not loaded");

  property p_chain;
    exec && f.cmd == CMD_CHAIN |=> setup_q.chain_en == $past(f.data[0]);
  endproperty
  a_chain: assert property (p_chain) else $error("chain enable not loaded");

  property p_nop;
    exec && (f.cmd == 4'h0 || f.cmd >= 4'ha) && !load_outputs_n_fall |=> $stable(setup_q) && $stable(dac_q[0]);
  endproperty
  a_nop: assert property (p_nop) else $error("reserved command changed state");

  property p_por;
    $rose(st_q == ST_IDLE) && $past(st_q) == ST_INIT |-> dac_q[1] == (pocs_q ? CODE_MID : CODE_ZERO);
  endproperty
  a_por: assert property (p_por) else $error("power-on code wrong");

  property p_settle;
    $rose(st_q == ST_BUSY) |-> ##[1:6] st_q == ST_IDLE;
  endproperty
  a_settle: assert property (p_settle) else $error("settle stall too long");

  c_write: cover property (exec && f.cmd == CMD_WR_UPD);
  c_load_outputs_n:  cover property (load_outputs_n_fall && st_q == ST_IDLE);
  c_abort: cover property (abort_ev);
  c_full:  cover property (!fifo_in_ready);
endmodule : qdc_command_port

// ---- verif/qdc_host_model.sv ----
// Host serial master that frames command words for the converter port
`timescale 1ns/10ps
module qdc_host_model #(
  parameter int HALF_NS = 24
) (
  input  wire logic reply_in,
  output logic      link_clk_out,
  output logic      frame_n_out,
  output logic      data_out
);
  logic [23:0] rx_word;

  initial begin
    rx_word      = 24'h000000;
    link_clk_out = 1'b0;
    frame_n_out  = 1'b1;
    data_out     = 1'b0;
  end

  // Clock only runs inside a frame; data moves on the falling edge
  task automatic send_frame(input logic [23:0] word, input int nbits);
    logic bit_v;
    bit_v = 1'b0;
    rx_word = 24'h000000;
    frame_n_out = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      bit_v = (i < 24) ? word[23-i] : 1'b0;
      data_out = bit_v;
      #(HALF_NS) link_clk_out = 1'b1;
      #(HALF_NS) link_clk_out = 1'b0;
      // Reply settled since the rising edge
      rx_word = {rx_word[22:0], reply_in};
    end
    #(HALF_NS) frame_n_out = 1'b1;
    // Released line shows the inverse, not a held value
    data_out = ~bit_v;
    #200;
  endtask : send_frame
endmodule : qdc_host_model

// ---- verif/tb_top.sv ----
// Self-checking bench for the quad converter command port
`timescale 1ns/10ps
module tb_top;
  import qdc_pkg::*;
  logic             sys_clk;
  logic             rst_n;
  logic             link_clk;
  logic             frame_n;
  logic             sdata;
  logic             sout;
  logic             load_n;
  logic             code_sel;
  logic             gain_sel;
  logic             gain_dbl;
  logic             busy;
  logic [3:0][15:0] codes;
  qdc_setup_type    setup;
  logic [3:0][15:0] exp_code;
  qdc_setup_type    exp_setup;
  int               mismatches;
  int               comparisons;

  qdc_command_port qdc_command_port_inst (
    .sys_clk_in              (sys_clk),
    .rst_n_in                (rst_n),
    .link_clk_in             (link_clk),
    .frame_n_in              (frame_n),
    .serial_in               (sdata),
    .serial_out_out          (sout),
    .load_outputs_n_in       (load_n),
    .power_on_code_select_in (code_sel),
    .gain_select_in          (gain_sel),
    .dac_code_out            (codes),
    .gain_double_out         (gain_dbl),
    .setup_out               (setup),
    .busy_out                (busy)
  );

  qdc_host_model qdc_host_model_inst (
    .reply_in     (sout),
    .link_clk_out (link_clk),
    .frame_n_out  (frame_n),
    .data_out     (sdata)
  );

  initial sys_clk = 1'b0;
  always #(CLK_NS/2) sys_clk = ~sys_clk;

  // ********************
  // Checking helpers
  // ********************
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic check_all();
    for (int c = 0; c < NUM_CH; c++) begin
      check($sformatf("code%0d", c), 32'(codes[c]), 32'(exp_code[c]));
    end
    check("setup", 32'(setup), 32'(exp_setup));
  endtask : check_all

  // Bounded wait for the port to go idle
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 40) begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 40) begin
      mismatches++;
      $display("ERROR busy expected 0 seen %b", busy);
      print_verdict();
    end
  endtask : wait_idle

  task automatic do_reset(input logic cs, input logic gs);
    @(negedge sys_clk);
    rst_n    = 1'b0;
    code_sel = cs;
    gain_sel = gs;
    repeat (6) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (2) @(negedge sys_clk);
    wait_idle();
    exp_code  = {4{cs ? CODE_MID : CODE_ZERO}};
    exp_setup = SETUP_RST;
  endtask : do_reset

  // Commit takes a handful of cycles after select rises
  task automatic send(input logic [3:0] cmd, input logic [3:0] addr, input logic [15:0] data, input int nbits);
    qdc_host_model_inst.send_frame({cmd, addr, data}, nbits);
    @(negedge sys_clk);
    repeat (8) @(negedge sys_clk);
    wait_idle();
  endtask : send

  // ********************
  // Scenarios
  // ********************
  task automatic t_power_on();
    check_all();
    check("gain", 32'(gain_dbl), 32'h0);
  endtask : t_power_on

  task automatic t_write_then_update();
    send(CMD_WR_IN, 4'h1, 16'h1234, 24);
    check_all();
    send(CMD_UPD, 4'h5, 16'h0000, 24);
    exp_code[0] = 16'h1234;
    check_all();
  endtask : t_write_then_update

  task automatic t_write_update_multi();
    send(CMD_WR_UPD, 4'h6, 16'habcd, 24);
    exp_code[1] = 16'habcd;
    exp_code[2] = 16'habcd;
    check_all();
  endtask : t_write_update_multi

  task automatic t_load_pin();
    load_n = 1'b0;
    send(CMD_WR_IN, 4'h8, 16'h5555, 24);
    exp_code[3] = 16'h5555;
    check_all();
    @(negedge sys_clk);
    load_n = 1'b1;
    send(CMD_MASK, 4'h0, 16'h0001, 24);
    exp_setup.load_mask = 4'h1;
    send(CMD_WR_IN, 4'h3, 16'h0f0f, 24);
    check_all();
    // Masked channel must ignore the pin edge
    @(negedge sys_clk);
    load_n = 1'b0;
    repeat (4) @(negedge sys_clk);
    load_n = 1'b1;
    repeat (6) @(negedge sys_clk);
    wait_idle();
    exp_code[1] = 16'h0f0f;
    check_all();
  endtask : t_load_pin

  task automatic t_setup_cmds();
    send(CMD_PWR, 4'hf, 16'h00a5, 24);
    exp_setup.power_down = 8'ha5;
    check_all();
    check("sdo_idle", 32'(qdc_host_model_inst.rx_word), 32'h0);
    send(CMD_REF, 4'h0, 16'h0001, 24);
    exp_setup.ref_disable = 1'b1;
    check_all();
    send(CMD_CHAIN, 4'h0, 16'h0001, 24);
    exp_setup.chain_en = 1'b1;
    check_all();
    // Enables cross on the stopped link clock: one frame to settle
    send(4'h0, 4'h0, 16'h3c5a, 24);
    send(4'h0, 4'h0, 16'h0000, 24);
    check("chain", 32'(qdc_host_model_inst.rx_word), 32'h00003c5a);
    send(CMD_CHAIN, 4'h0, 16'h0000, 24);
    exp_setup.chain_en = 1'b0;
    check_all();
    send(CMD_RDBK, 4'h1, 16'h0001, 24);
    exp_setup.readback_en = 1'b1;
    check_all();
    send(4'h0, 4'h0, 16'h0000, 24);
    send(4'h0, 4'h0, 16'h0000, 24);
    check("readback", 32'(qdc_host_model_inst.rx_word), 32'({CMD_RDBK, 4'h1, 16'h0f0f}));
    send(CMD_RDBK, 4'h0, 16'h0000, 24);
    exp_setup.readback_en = 1'b0;
    check_all();
  endtask : t_setup_cmds

  task automatic t_ignored();
    logic [3:0] cmds [7];
    cmds = '{4'h0, 4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'hf};
    foreach (cmds[i]) begin
      send(cmds[i], 4'hf, 16'hffff, 24);
      check_all();
    end
  endtask : t_ignored

  task automatic t_bad_length();
    send(CMD_WR_UPD, 4'hf, 16'h1111, 23);
    check_all();
    send(CMD_WR_UPD, 4'hf, 16'h2222, 25);
    check_all();
  endtask : t_bad_length

  task automatic t_soft_reset();
    send(CMD_SRST, 4'h0, 16'h0000, 24);
    exp_code  = {4{CODE_ZERO}};
    exp_setup = SETUP_RST;
    check_all();
  endtask : t_soft_reset

  task automatic t_straps_high();
    do_reset(1'b1, 1'b1);
    check_all();
    check("gain", 32'(gain_dbl), 32'h1);
    send(CMD_WR_UPD, 4'h9, 16'hffff, 24);
    send(CMD_SRST, 4'h0, 16'h0000, 24);
    check_all();
  endtask : t_straps_high

  // ********************
  // Main sequence
  // ********************
  initial begin
    mismatches  = 0;
    comparisons = 0;
    rst_n       = 1'b0;
    load_n      = 1'b1;
    code_sel    = 1'b0;
    gain_sel    = 1'b0;
    exp_code    = '0;
    exp_setup   = SETUP_RST;
    do_reset(1'b0, 1'b0);
    t_power_on();
    t_write_then_update();
    t_write_update_multi();
    t_load_pin();
    t_setup_cmds();
    t_ignored();
    t_bad_length();
    t_soft_reset();
    t_straps_high();
    print_verdict();
  end
endmodule : tb_top
